// [include/spp_pkg.sv]
// package: constants for the serial peripheral-mode port
package spp_pkg;
  localparam int unsigned CTL_CONTROLLER_BIT = 0;
  localparam int unsigned FMT_PHASE_BIT = 16;
  localparam int unsigned FMT_POLARITY_BIT = 17;
  localparam int unsigned FMT_PRESCALE_LSB = 8;
  localparam int unsigned FMT_PRESCALE_MSB = 15;
  localparam int unsigned FMT_WIDTH = 32;
  localparam int unsigned CTL_WIDTH = 32;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CNT_WIDTH = 5;
  localparam int unsigned PRESCALE_WIDTH = 8;
  localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_ZERO = 8'h00;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_WIDTH-1:0] CNT_LAST = 5'h0F;
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
  // period monitor counts, one bit wider than the prescale field
  localparam logic [PRESCALE_WIDTH:0] PER_ZERO = 9'h000;
  localparam logic [PRESCALE_WIDTH:0] PER_ONE = 9'h001;
  localparam logic [PRESCALE_WIDTH:0] PER_MAX = 9'h1FF;
  localparam logic [PRESCALE_WIDTH:0] PER_PS_ZERO = 9'h002; // two internal cycles when prescale is 0
  // synchroniser reset levels: data low, select high, clock low
  localparam logic [2:0] PIN_IDLE = 3'h2;
  // least serial clock period in ns and its cycle count at 200 MHz
  localparam int unsigned SCLK_MIN_NS = 25;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SCLK_MIN_CYC = (SCLK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // edge event codes
  typedef enum logic [1:0] {
    SPP_EDGE_NONE = 2'b00,
    SPP_EDGE_RISE = 2'b01,
    SPP_EDGE_FALL = 2'b10
  } spp_edge_e;
endpackage

// [include/spp_pin_if.sv]
// interface: synchronised pin levels and edge events between sampler and core
`timescale 1ns/1ps
interface spp_pin_if;
  logic sclk_lvl;
  logic cs_n_lvl;
  logic mosi_lvl;
  spp_pkg::spp_edge_e sclk_edge;
  logic cs_fall;
  logic cs_rise;
  modport sampler (output sclk_lvl, output cs_n_lvl, output mosi_lvl, output sclk_edge, output cs_fall,
    output cs_rise);
  modport core (input sclk_lvl, input cs_n_lvl, input mosi_lvl, input sclk_edge, input cs_fall, input cs_rise);
endinterface

// [src/spp_pin_sync.sv]
// module: three-stage pin synchronisers with edge detection
`timescale 1ns/1ps
module spp_pin_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic serial_clock_pin,
  input wire logic cs_n_pin,
  input wire logic host_to_dev_data,
  spp_pin_if.sampler pins
);
  localparam int unsigned NPIN = 3;
  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff;
  logic [NPIN-1:0] nxt_s1, nxt_s2, nxt_s3;
  logic [NPIN-1:0] lvl_ff, nxt_lvl;

  // ==========================================================
  // synchroniser chain
  always_comb begin
    nxt_s1 = {host_to_dev_data, cs_n_pin, serial_clock_pin};
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_lvl = lvl_ff;
    for (int i = 0; i < NPIN; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin // agreed change counts
        nxt_lvl[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_ff <= spp_pkg::PIN_IDLE;
      s2_ff <= spp_pkg::PIN_IDLE;
      s3_ff <= spp_pkg::PIN_IDLE;
      lvl_ff <= spp_pkg::PIN_IDLE;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      lvl_ff <= nxt_lvl;
    end
  end

  // ==========================================================
  // levels and edge events
  assign pins.sclk_lvl = lvl_ff[0];
  assign pins.cs_n_lvl = lvl_ff[1];
  assign pins.mosi_lvl = lvl_ff[2];
  assign pins.cs_fall = lvl_ff[1] & ~nxt_lvl[1];
  assign pins.cs_rise = ~lvl_ff[1] & nxt_lvl[1];
  assign pins.sclk_edge = (~lvl_ff[0] & nxt_lvl[0]) ? spp_pkg::SPP_EDGE_RISE :
                          (lvl_ff[0] & ~nxt_lvl[0]) ? spp_pkg::SPP_EDGE_FALL : spp_pkg::SPP_EDGE_NONE;
endmodule // spp_pin_sync

// [src/spp_periph_port.sv]
// module: serial peripheral-mode port core
`timescale 1ns/1ps
module spp_periph_port #(
  parameter int unsigned WORD_BITS = spp_pkg::WORD_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [spp_pkg::CTL_WIDTH-1:0] spi_global_control,
  input wire logic [spp_pkg::FMT_WIDTH-1:0] spi_format_control,
  input wire logic serial_clock_pin,
  input wire logic cs_n_pin,
  input wire logic host_to_dev_data,
  input wire logic [WORD_BITS-1:0] tx_word,
  output logic dev_to_host_data,
  output logic dev_to_host_oe,
  output logic [WORD_BITS-1:0] rx_word,
  output logic rx_valid,
  output logic tx_taken,
  output logic clock_too_fast
);
  spp_pin_if pins ();

  // pin synchronisers feed the core through the interface
  spp_pin_sync u_sync (
    .clk(clk),
    .srst(srst),
    .serial_clock_pin(serial_clock_pin),
    .cs_n_pin(cs_n_pin),
    .host_to_dev_data(host_to_dev_data),
    .pins(pins)
  );

  // ==========================================================
  // configuration decode
  logic periph_mode;
  logic phase;
  logic polarity;
  logic rise_launch;
  logic [spp_pkg::PRESCALE_WIDTH-1:0] prescale_field;
  logic [spp_pkg::PRESCALE_WIDTH:0] min_period;
  assign periph_mode = ~spi_global_control[spp_pkg::CTL_CONTROLLER_BIT];
  assign phase = spi_format_control[spp_pkg::FMT_PHASE_BIT];
  assign polarity = spi_format_control[spp_pkg::FMT_POLARITY_BIT];
  assign prescale_field = spi_format_control[spp_pkg::FMT_PRESCALE_MSB:spp_pkg::FMT_PRESCALE_LSB];
  assign rise_launch = (polarity == phase);
  // least legal period in internal cycles
  assign min_period = (prescale_field == spp_pkg::PRESCALE_ZERO) ? spp_pkg::PER_PS_ZERO :
                      ({1'b0, prescale_field} + spp_pkg::PER_ONE);

  // true when a synced clock event runs in the wanted direction
  function automatic logic edge_is(input spp_pkg::spp_edge_e ev, input logic want_rise);
    return want_rise ? (ev == spp_pkg::SPP_EDGE_RISE) : (ev == spp_pkg::SPP_EDGE_FALL);
  endfunction

  // launch and sample event decode; events count only while selected as peripheral
  logic launch_ev;
  logic sample_ev;
  logic active;
  assign active = periph_mode & ~pins.cs_n_lvl;
  assign launch_ev = active & edge_is(pins.sclk_edge, rise_launch);
  assign sample_ev = active & edge_is(pins.sclk_edge, ~rise_launch);

  // ==========================================================
  // shift state: receive shifter, transmit shifter and held word
  logic [WORD_BITS-1:0] rx_sh_ff;
  logic [WORD_BITS-1:0] nxt_rx_sh;
  logic [WORD_BITS-1:0] tx_sh_ff;
  logic [WORD_BITS-1:0] nxt_tx_sh;
  logic [WORD_BITS-1:0] rx_word_ff;
  logic [WORD_BITS-1:0] nxt_rx_word;
  // bit counter within the current select pulse
  logic [spp_pkg::CNT_WIDTH-1:0] cnt_ff;
  logic [spp_pkg::CNT_WIDTH-1:0] nxt_cnt;
  // output pin, strobes and first-edge marker
  logic sdo_ff;
  logic nxt_sdo;
  logic oe_ff;
  logic nxt_oe;
  logic rxv_ff;
  logic nxt_rxv;
  logic taken_ff;
  logic nxt_taken;
  logic first_ff;
  logic nxt_first;

  // next shift state: load at select, shift on synced clock events
  always_comb begin
    nxt_rx_sh = rx_sh_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rx_word = rx_word_ff;
    nxt_cnt = cnt_ff;
    nxt_sdo = sdo_ff;
    nxt_oe = active;
    nxt_rxv = 1'b0;
    nxt_taken = 1'b0;
    nxt_first = first_ff;
    if (periph_mode && pins.cs_fall) begin
      // select seen: msb goes out now, since in phase 1 the first edge already samples it
      nxt_sdo = tx_word[WORD_BITS-1];
      nxt_tx_sh = {tx_word[WORD_BITS-2:0], 1'b0};
      nxt_taken = 1'b1;
      nxt_first = 1'b1;
      nxt_cnt = spp_pkg::CNT_ZERO;
    end else if (!active) begin
      nxt_cnt = spp_pkg::CNT_ZERO;
      nxt_first = 1'b1;
      nxt_sdo = 1'b0;
    end else begin
      // phase 0 opens on a launch edge, which must not move the msb away
      if (launch_ev && (phase || !first_ff)) begin
        nxt_sdo = tx_sh_ff[WORD_BITS-1];
        nxt_tx_sh = {tx_sh_ff[WORD_BITS-2:0], 1'b0};
      end
      if (launch_ev) begin
        nxt_first = 1'b0;
      end
      if (sample_ev) begin
        nxt_rx_sh = {rx_sh_ff[WORD_BITS-2:0], pins.mosi_lvl};
        nxt_cnt = cnt_ff + spp_pkg::CNT_ONE;
        if (cnt_ff == spp_pkg::CNT_LAST) begin // 16th bit, word complete
          nxt_rx_word = {rx_sh_ff[WORD_BITS-2:0], pins.mosi_lvl};
          nxt_rxv = 1'b1;
          nxt_cnt = spp_pkg::CNT_ZERO;
        end
      end
    end
  end

  // shift state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_sh_ff <= spp_pkg::WORD_ZERO;
      tx_sh_ff <= spp_pkg::WORD_ZERO;
      rx_word_ff <= spp_pkg::WORD_ZERO;
      cnt_ff <= spp_pkg::CNT_ZERO;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      rxv_ff <= 1'b0;
      taken_ff <= 1'b0;
      first_ff <= 1'b1;
    end else begin
      rx_sh_ff <= nxt_rx_sh;
      tx_sh_ff <= nxt_tx_sh;
      rx_word_ff <= nxt_rx_word;
      cnt_ff <= nxt_cnt;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
      rxv_ff <= nxt_rxv;
      taken_ff <= nxt_taken;
      first_ff <= nxt_first;
    end
  end

  // ==========================================================
  // serial clock period monitor
  logic [spp_pkg::PRESCALE_WIDTH:0] per_ff;
  logic [spp_pkg::PRESCALE_WIDTH:0] nxt_per;
  logic fast_ff;
  logic nxt_fast;
  logic seen_ff;
  logic nxt_seen;

  // rising-to-rising period against the least legal period
  always_comb begin
    nxt_per = per_ff;
    nxt_fast = fast_ff;
    nxt_seen = seen_ff;
    // clear first, so a short period in the same cycle still sets the flag
    if (pins.cs_rise) begin
      nxt_fast = 1'b0;
    end
    if (!active) begin
      nxt_seen = 1'b0;
      nxt_per = spp_pkg::PER_ZERO;
    end else if (edge_is(pins.sclk_edge, 1'b1)) begin
      if (seen_ff && ((per_ff + spp_pkg::PER_ONE) < min_period)) begin
        nxt_fast = 1'b1;
      end
      nxt_seen = 1'b1;
      nxt_per = spp_pkg::PER_ZERO;
    end else if (per_ff != spp_pkg::PER_MAX) begin
      nxt_per = per_ff + spp_pkg::PER_ONE; // saturates on a stopped clock
    end
  end

  // period monitor registers
  always_ff @(posedge clk) begin
    if (srst) begin
      per_ff <= spp_pkg::PER_ZERO;
      fast_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      per_ff <= nxt_per;
      fast_ff <= nxt_fast;
      seen_ff <= nxt_seen;
    end
  end

  // ==========================================================
  // pin and status outputs, all straight from registers
  assign dev_to_host_data = sdo_ff;
  assign dev_to_host_oe = oe_ff;
  assign rx_word = rx_word_ff;
  assign rx_valid = rxv_ff;
  assign tx_taken = taken_ff;
  assign clock_too_fast = fast_ff;
endmodule // spp_periph_port

// [tb/spp_host_model.sv]
// host model: serial controller driving clock, select and data
`timescale 1ns/1ps
module spp_host_model (
  input wire logic clk,
  input wire logic dev_to_host_data,
  output logic serial_clock_pin,
  output logic cs_n_pin,
  output logic host_to_dev_data
);
  // ==========
  // idle levels
  initial begin
    serial_clock_pin = 1'b0;
    cs_n_pin = 1'b1;
    host_to_dev_data = 1'b0;
  end
  // one select pulse of nb clocks, msb first
  task automatic frame(input logic [15:0] w, input int nb, input int half, input logic pol, input logic pha,
    output logic [15:0] got);
    got = 16'h0000;
    serial_clock_pin <= pol; // clock stands still at idle
    repeat (half) @(posedge clk);
    cs_n_pin <= 1'b0;
    repeat (4 * half) @(posedge clk); // two clock periods first
    for (int i = 0; i < nb; i++) begin
      if (pha) host_to_dev_data <= w[15 - i]; // phase 1: ahead of the sampling first edge
      repeat (half) @(posedge clk);
      serial_clock_pin <= ~pol;
      if (!pha) host_to_dev_data <= w[15 - i]; // phase 0: on the launch edge
      if (pha) got = {got[14:0], dev_to_host_data};
      repeat (half) @(posedge clk);
      serial_clock_pin <= pol;
      if (!pha) got = {got[14:0], dev_to_host_data};
    end
    repeat (half) @(posedge clk);
    cs_n_pin <= 1'b1; // one pulse per word
    host_to_dev_data <= ~host_to_dev_data; // no stale level
    repeat (half) @(posedge clk);
  endtask
endmodule // spp_host_model

// [tb/spp_periph_port_checker.sv]
// checker: properties on the peripheral port pins and status outputs
`timescale 1ns/1ps
module spp_periph_port_checker #(
  parameter int unsigned WORD_BITS = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] spi_global_control,
  input wire logic [31:0] spi_format_control,
  input wire logic serial_clock_pin,
  input wire logic cs_n_pin,
  input wire logic host_to_dev_data,
  input wire logic [WORD_BITS-1:0] tx_word,
  input wire logic dev_to_host_data,
  input wire logic dev_to_host_oe,
  input wire logic [WORD_BITS-1:0] rx_word,
  input wire logic rx_valid,
  input wire logic tx_taken,
  input wire logic clock_too_fast
);
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_ctl_idle; spi_global_control[0] [*3] |-> !dev_to_host_oe; endproperty
  a_ctl_idle: assert property (p_ctl_idle) else $error("driving in controller mode");
  property p_desel; cs_n_pin [*8] |-> !dev_to_host_oe && !dev_to_host_data; endproperty
  a_desel: assert property (p_desel) else $error("driving while deselected");
  property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("word pulse too long");
  property p_tx_pulse; tx_taken |=> !tx_taken; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("load pulse too long");
  property p_rx_hold; $changed(rx_word) |-> rx_valid; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("word changed without pulse");
  property p_take_oe; tx_taken |-> ##[0:2] dev_to_host_oe; endproperty
  a_take_oe: assert property (p_take_oe) else $error("no drive after load");
  property p_fast_hold; !cs_n_pin [*8] ##0 clock_too_fast |=> clock_too_fast; endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("flag lost in frame");
  property p_valid_sel; rx_valid |-> dev_to_host_oe; endproperty
  a_valid_sel: assert property (p_valid_sel) else $error("word outside select");
  c_rx: cover property (rx_valid);
  c_tx: cover property (tx_taken);
  c_fast: cover property (clock_too_fast);
endmodule // spp_periph_port_checker
bind spp_periph_port spp_periph_port_checker #(.WORD_BITS(WORD_BITS)) chk (.*);

// [tb/test_spi_peripheral_mode_port.sv]
// testbench: random and corner frames through the peripheral port
`timescale 1ns/1ps
module test_spi_peripheral_mode_port;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] spi_global_control = 32'h0;
  logic [31:0] spi_format_control = 32'h0;
  logic [15:0] tx_word = 16'h0;
  logic serial_clock_pin, cs_n_pin, host_to_dev_data, dev_to_host_data, dev_to_host_oe;
  logic rx_valid, tx_taken, clock_too_fast;
  logic [15:0] rx_word, got, w;
  int failures = 0, compares = 0, nvalid = 0, nfast = 0, ntaken = 0, cyc = 0;
  spp_periph_port dut (.*);
  spp_host_model host (.*);
  // ==========
  // clock, event counts and ceiling
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) nvalid <= nvalid + 1;
    if (tx_taken === 1'b1) ntaken <= ntaken + 1;
    if (clock_too_fast === 1'b1) nfast <= nfast + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  // flag expected for a period in cycles
  function automatic logic fast_exp(input logic [7:0] ps, input int per);
    return per < ((ps == 8'h00) ? 2 : ps + 1);
  endfunction
  task automatic check(input logic [15:0] a, input logic [15:0] e, input string m);
    compares++;
    if (a !== e) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one frame with mode, prescale and control bit
  task automatic xfer(input int nb, input logic [7:0] ps, input logic [1:0] md, input logic c0);
    int n0, f0, t0;
    logic ok;
    w = 16'($urandom());
    ok = !c0 && nb == 16;
    @(posedge clk);
    spi_global_control <= {31'h0, c0};
    spi_format_control <= {14'h0, md, ps, 8'h00};
    tx_word <= 16'($urandom());
    n0 = nvalid;
    f0 = nfast;
    t0 = ntaken;
    host.frame(w, nb, 8, md[1], md[0], got);
    check(16'(nvalid - n0), {15'h0, ok}, "word count");
    check(16'(ntaken - t0), {15'h0, !c0}, "load count");
    if (ok) check(rx_word, w, "received word");
    if (ok) check(got, tx_word, "sent word");
    check({15'h0, nfast != f0}, {15'h0, fast_exp(ps, 16)}, "period flag");
    check({15'h0, clock_too_fast}, 16'h0, "flag after select");
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'h2a068155));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 12; i++) xfer(16, (i < 4) ? 8'h00 : 8'($urandom_range(14)), 2'(i), 1'b0);
    xfer(8, 8'h03, 2'h0, 1'b0);
    xfer(16, 8'h03, 2'h0, 1'b0);
    xfer(16, 8'h02, 2'h3, 1'b1);
    xfer(16, 8'hFF, 2'h1, 1'b0);
    xfer(16, 8'h0F, 2'h2, 1'b0);
    stop_test();
  end
endmodule // test_spi_peripheral_mode_port
